// File: logic/pbs_map.svh
// constants for the pipelined burst sram access block
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH
`define PBS_AW        8
`define PBS_LANES     4
`define PBS_LANE_W    9
`define PBS_DW        36
`define PBS_CTR_W     2
`define PBS_ORDER_RST 1'b1
`define PBS_STEP_ONE  2'h1
`define PBS_STEP_RST  2'h0
`endif

// File: logic/pbs_pkg.sv
// types shared by the pipelined burst sram access block
package pbs_pkg;
  typedef enum logic [1:0] {
    PBS_CYC_NONE  = 2'b00,
    PBS_CYC_READ  = 2'b01,
    PBS_CYC_WRITE = 2'b10,
    PBS_CYC_DESEL = 2'b11
  } pbs_cyc_e;
  typedef enum logic {
    PBS_ST_DESEL  = 1'b0,
    PBS_ST_ACTIVE = 1'b1
  } pbs_state_e;
endpackage

// File: logic/pbs_burst_ctr.sv
// two-bit wraparound burst address counter, linear or interleaved
`timescale 1ns/10ps
`default_nettype none
`include "pbs_map.svh"
module pbs_burst_ctr (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // control
  input  wire logic                  load_in,
  input  wire logic [`PBS_CTR_W-1:0] seed_in,
  input  wire logic                  adv_in,
  input  wire logic                  interleave_in,
  // burst address
  output logic      [`PBS_CTR_W-1:0] cur_out,
  output logic      [`PBS_CTR_W-1:0] next_out
);
  logic [`PBS_CTR_W-1:0] seed_r;
  logic [`PBS_CTR_W-1:0] seed_nxt;
  logic [`PBS_CTR_W-1:0] step_r;
  logic [`PBS_CTR_W-1:0] step_nxt;
  logic [`PBS_CTR_W-1:0] step_up;

  assign step_up = step_r + `PBS_STEP_ONE;
  // interleaved order is the start value xor the step count
  assign cur_out  = interleave_in ? (seed_r ^ step_r)  : (seed_r + step_r);
  assign next_out = interleave_in ? (seed_r ^ step_up) : (seed_r + step_up);

  always_comb
  begin
    seed_nxt = seed_r;
    step_nxt = step_r;
    if (load_in)
    begin
      seed_nxt = seed_in;         // RQ5
      step_nxt = `PBS_STEP_RST;
    end
    else if (adv_in)
    begin
      step_nxt = step_up;         // RQ20
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      seed_r <= `PBS_STEP_RST;
      step_r <= `PBS_STEP_RST;
    end
    else
    begin
      seed_r <= seed_nxt;
      step_r <= step_nxt;
    end
  end
endmodule
`default_nettype wire

// File: logic/pbs_mem.sv
// byte-lane writable array with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "pbs_map.svh"
module pbs_mem (
  // clock
  input  wire logic                  clk_in,
  // access
  input  wire logic [`PBS_AW-1:0]    addr_in,
  input  wire logic [`PBS_LANES-1:0] lane_we_in,
  input  wire logic [`PBS_DW-1:0]    wdata_in,
  output logic      [`PBS_DW-1:0]    rdata_out
);
  // one array per lane, so that every array has a single writing process
  for (genvar i = 0; i < `PBS_LANES; i++)
  begin : g_lane
    logic [`PBS_LANE_W-1:0] lane_mem_r [0:(1<<`PBS_AW)-1];
    logic [`PBS_LANE_W-1:0] lane_q_r;

    // lanes not enabled keep their old contents; a read sees the old word
    always_ff @(posedge clk_in)
    begin
      if (lane_we_in[i])
      begin
        lane_mem_r[addr_in] <= wdata_in[i*`PBS_LANE_W +: `PBS_LANE_W];
      end
      lane_q_r <= lane_mem_r[addr_in];
    end

    assign rdata_out[i*`PBS_LANE_W +: `PBS_LANE_W] = lane_q_r;
  end
endmodule
`default_nettype wire

// File: logic/pbs_sram.sv
// synchronous access logic of a pipelined burst static memory
//
// Contract
// RQ1: strap low linear, high interleaved burst order
// RQ2: system keeps the order strap constant
// RQ3: inputs and read data pass edge registers
// RQ4: burst addresses come from counter, not pins
// RQ5: low address bits seed two-bit wrap counter
// RQ6: global write writes every byte lane
// RQ7: processor strobe ignored while primary select high
// RQ8: strobe, selects active, no write starts read
// RQ9: start stores address in register and counter
// RQ10: read data driven after next edge, enable low
// RQ11: first cycle after deselect stays tri-stated
// RQ12: deselecting edge tri-states outputs at once
// RQ13: back-to-back single reads need no gap
// RQ14: processor start ignores write and advance
// RQ15: processor write completes at second edge
// RQ16: byte write only on selected lanes
// RQ17: controller raises output enable before write data
// RQ18: any write cycle tri-states data drivers
// RQ19: both strobes low, processor strobe wins
// RQ20: counter counts up or follows xor pattern
// RQ21: advance low steps the burst counter
// RQ22: idle strobes, advance high repeats address
// RQ23: output enable high always tri-states outputs
`timescale 1ns/10ps
`default_nettype none
`include "pbs_map.svh"
module pbs_sram (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // address and selects
  input  wire logic [`PBS_AW-1:0]    addr_in,
  input  wire logic                  chip_select_primary_n_in,
  input  wire logic                  chip_select_second_in,
  input  wire logic                  chip_select_third_n_in,
  // burst control
  input  wire logic                  processor_addr_strobe_n_in,
  input  wire logic                  controller_addr_strobe_n_in,
  input  wire logic                  burst_advance_n_in,
  input  wire logic                  burst_order_in,
  // write control
  input  wire logic                  global_write_n_in,
  input  wire logic                  lane_write_enable_n_in,
  input  wire logic [`PBS_LANES-1:0] lane_select_n_in,
  // data bus
  input  wire logic                  out_enable_n_in,
  input  wire logic [`PBS_DW-1:0]    dq_in,
  output logic      [`PBS_DW-1:0]    dq_out,
  output logic                       dq_oe_out
);
  import pbs_pkg::*;

  logic                  rst_s1_r;
  logic                  rst_n_r;
  logic                  ord_s1_r;
  logic                  ord_s2_r;
  logic                  ord_s3_r;
  logic                  order_r;
  logic                  order_nxt;
  pbs_state_e            state_r;
  pbs_state_e            state_nxt;
  logic [`PBS_AW-1:0]    addr_r;
  logic [`PBS_AW-1:0]    addr_nxt;
  logic                  rd_issue_r;
  logic                  rd_issue_nxt;
  logic                  drv_r;
  logic                  drv_nxt;
  logic [`PBS_DW-1:0]    dq_r;
  logic [`PBS_DW-1:0]    dq_nxt;
  pbs_cyc_e              cyc_c;
  logic                  selected;
  logic                  proc_go;
  logic                  ctrl_go;
  logic                  wr_ctl;
  logic [`PBS_LANES-1:0] lane_we;
  logic [`PBS_LANES-1:0] mem_we;
  logic                  load;
  logic                  burst_advance_n;
  logic [`PBS_AW-1:0]    acc_addr;
  logic [`PBS_CTR_W-1:0] ctr_cur;
  logic [`PBS_CTR_W-1:0] ctr_next;
  logic [`PBS_DW-1:0]    mem_rdata;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // order strap is a static pin; a change counts once two late stages agree
  always_comb
  begin
    order_nxt = order_r;
    if (ord_s2_r == ord_s3_r)
    begin
      order_nxt = ord_s3_r;       // RQ1 RQ2
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ord_s1_r <= `PBS_ORDER_RST;
      ord_s2_r <= `PBS_ORDER_RST;
      ord_s3_r <= `PBS_ORDER_RST;
      order_r  <= `PBS_ORDER_RST;
    end
    else
    begin
      ord_s1_r <= burst_order_in;
      ord_s2_r <= ord_s1_r;
      ord_s3_r <= ord_s2_r;
      order_r  <= order_nxt;
    end
  end

  // edge decode of the synchronous pins
  assign selected = !chip_select_primary_n_in && chip_select_second_in
                    && !chip_select_third_n_in;
  assign proc_go  = !processor_addr_strobe_n_in && !chip_select_primary_n_in; // RQ7
  assign ctrl_go  = !controller_addr_strobe_n_in && !proc_go;                 // RQ19
  assign wr_ctl   = !global_write_n_in || !lane_write_enable_n_in;
  // global write overrides byte enables
  assign lane_we  = !global_write_n_in ? {`PBS_LANES{1'b1}}                    // RQ6
                  : ({`PBS_LANES{!lane_write_enable_n_in}} & ~lane_select_n_in); // RQ16

  always_comb
  begin
    cyc_c    = PBS_CYC_NONE;
    load     = 1'b0;
    burst_advance_n      = 1'b0;
    acc_addr = addr_in;
    if (proc_go || ctrl_go)
    begin
      if (selected)
      begin
        load = 1'b1;              // RQ9
        // processor start is always a read first cycle
        cyc_c = (ctrl_go && wr_ctl) ? PBS_CYC_WRITE : PBS_CYC_READ; // RQ8 RQ14
      end
      else
      begin
        cyc_c = PBS_CYC_DESEL;    // RQ12
      end
    end
    else if (state_r == PBS_ST_ACTIVE)
    begin
      burst_advance_n      = !burst_advance_n_in;                                  // RQ21 RQ22
      acc_addr = {addr_r[`PBS_AW-1:`PBS_CTR_W], burst_advance_n ? ctr_next : ctr_cur}; // RQ4
      cyc_c    = wr_ctl ? PBS_CYC_WRITE : PBS_CYC_READ;                // RQ15
    end
  end

  assign mem_we = (cyc_c == PBS_CYC_WRITE) ? lane_we : {`PBS_LANES{1'b0}};

  // access state and pipeline
  always_comb
  begin
    state_nxt    = state_r;
    addr_nxt     = addr_r;
    rd_issue_nxt = (cyc_c == PBS_CYC_READ);
    dq_nxt       = rd_issue_r ? mem_rdata : dq_r;    // RQ3
    drv_nxt      = rd_issue_r;                       // RQ10 RQ11 RQ13
    if (load)
    begin
      state_nxt = PBS_ST_ACTIVE;
      addr_nxt  = addr_in;                           // RQ9
    end
    else if (cyc_c == PBS_CYC_DESEL)
    begin
      state_nxt = PBS_ST_DESEL;
    end
    if (cyc_c == PBS_CYC_DESEL || cyc_c == PBS_CYC_WRITE)
    begin
      drv_nxt = 1'b0;                                // RQ12 RQ18
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r    <= PBS_ST_DESEL;
      addr_r     <= {`PBS_AW{1'b0}};
      rd_issue_r <= 1'b0;
      drv_r      <= 1'b0;
      dq_r       <= {`PBS_DW{1'b0}};
    end
    else
    begin
      state_r    <= state_nxt;
      addr_r     <= addr_nxt;
      rd_issue_r <= rd_issue_nxt;
      drv_r      <= drv_nxt;
      dq_r       <= dq_nxt;
    end
  end

  assign dq_out = dq_r;
  // output enable acts without the clock; a pending write blocks drive too
  assign dq_oe_out = drv_r && !out_enable_n_in && (cyc_c != PBS_CYC_WRITE); // RQ18 RQ23

  pbs_burst_ctr u_ctr (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_r),
    .load_in       (load),
    .seed_in       (addr_in[`PBS_CTR_W-1:0]),
    .adv_in        (burst_advance_n),
    .interleave_in (order_r),
    .cur_out       (ctr_cur),
    .next_out      (ctr_next)
  );

  pbs_mem u_mem (
    .clk_in     (clk_in),
    .addr_in    (acc_addr),
    .lane_we_in (mem_we),
    .wdata_in   (dq_in),
    .rdata_out  (mem_rdata)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_r);

  a_desel_tristate: assert property ( // RQ12
    cyc_c == PBS_CYC_DESEL |=> !drv_r && !dq_oe_out)
    else $error("outputs not released after deselect");

  a_read_latency: assert property ( // RQ10
    (cyc_c == PBS_CYC_READ) ##1 (cyc_c == PBS_CYC_READ || cyc_c == PBS_CYC_NONE)
    |=> drv_r && dq_r == $past(mem_rdata))
    else $error("read data not presented one edge after issue");

  a_first_cycle_off: assert property ( // RQ11
    state_r == PBS_ST_DESEL && load |=> !dq_oe_out)
    else $error("outputs driven in first cycle after deselect");

  a_oe_blocks: assert property ( // RQ23
    out_enable_n_in |-> !dq_oe_out)
    else $error("driving while output enable high");

  a_write_tristate: assert property ( // RQ18
    cyc_c == PBS_CYC_WRITE |-> !dq_oe_out ##1 !drv_r)
    else $error("driving during a write cycle");

  a_global_lanes: assert property ( // RQ6
    cyc_c == PBS_CYC_WRITE && !global_write_n_in |-> &mem_we)
    else $error("global write missed a lane");

  a_lane_only: assert property ( // RQ16
    cyc_c == PBS_CYC_WRITE && global_write_n_in
    |-> (mem_we & lane_select_n_in) == {`PBS_LANES{1'b0}})
    else $error("unselected lane written");

  a_proc_ignored: assert property ( // RQ7
    chip_select_primary_n_in && controller_addr_strobe_n_in |-> !load)
    else $error("processor strobe taken while primary select high");

  a_proc_read: assert property ( // RQ14 RQ19
    proc_go && selected |-> cyc_c == PBS_CYC_READ && !burst_advance_n)
    else $error("processor start not a plain read");

  a_seed_load: assert property ( // RQ5 RQ9
    load |=> ctr_cur == $past(addr_in[`PBS_CTR_W-1:0]) && addr_r == $past(addr_in))
    else $error("start address not captured");

  a_burst_step: assert property ( // RQ20 RQ21
    burst_advance_n && !order_r && order_nxt == order_r
    |=> ctr_cur == `PBS_CTR_W'($past(ctr_cur) + `PBS_STEP_ONE))
    else $error("linear burst did not step");

  a_burst_xor: assert property ( // RQ20
    load ##1 (burst_advance_n && order_r && order_nxt == order_r)
    |=> ctr_cur == ($past(addr_in[`PBS_CTR_W-1:0], 2) ^ `PBS_STEP_ONE))
    else $error("interleaved burst wrong");

  a_burst_hold: assert property ( // RQ22 RQ4
    state_r == PBS_ST_ACTIVE && !load && cyc_c != PBS_CYC_DESEL && !burst_advance_n
    |-> acc_addr[`PBS_CTR_W-1:0] == ctr_cur ##1 $stable(ctr_cur))
    else $error("burst address moved without advance");

  c_back_to_back: cover property (
    cyc_c == PBS_CYC_READ && load ##1 cyc_c == PBS_CYC_READ && load ##1 drv_r);
  c_proc_write: cover property (
    proc_go && selected ##1 cyc_c == PBS_CYC_WRITE);
  c_full_burst: cover property (
    load ##1 burst_advance_n [*3]);
  c_deselect: cover property (
    drv_r ##0 cyc_c == PBS_CYC_DESEL);
endmodule
`default_nettype wire

// File: tb/pbs_host_model.sv
// controller-side model of the shared data bus
`timescale 1ns/10ps
`default_nettype none
`include "pbs_map.svh"
module pbs_host_model (
  // clock
  input  wire logic               clk_in,
  // controller side
  input  wire logic               oe_n_in,
  input  wire logic               wr_drive_in,
  input  wire logic [`PBS_DW-1:0] wdata_in,
  // memory side
  input  wire logic [`PBS_DW-1:0] mem_q_in,
  input  wire logic               mem_oe_in,
  // resolved bus
  output logic      [`PBS_DW-1:0] bus_out
);
  logic [`PBS_DW-1:0] last_r;
  logic               host_on;
  // write data goes out only once output enable is high
  assign host_on = wr_drive_in && oe_n_in;
  always_comb
  begin
    if (mem_oe_in)
      bus_out = mem_q_in;
    else if (host_on)
      bus_out = wdata_in;
    else
      bus_out = ~last_r; // no keeper: a stale value must not look valid
  end
  always_ff @(posedge clk_in)
    last_r <= bus_out;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the pipelined burst sram access block
`timescale 1ns/10ps
`default_nettype none
`include "pbs_map.svh"
module tb_top;
  logic               clk_in;
  logic               rst_n_in;
  logic               strap;
  // 0 sel1_n,1 sel2,2 sel3_n,3 proc_n,4 ctrl_n,5 adv_n,6 gw_n,7 lane_wr_n,
  // 11:8 lane_sel_n,12 oe_n,20:13 address
  logic [20:0]        pin;
  logic [`PBS_DW-1:0] wdata;
  logic [`PBS_DW-1:0] dq_out;
  logic [`PBS_DW-1:0] bus;
  logic               dq_oe_out;
  logic [`PBS_DW-1:0] mem [0:255];
  logic [`PBS_DW-1:0] pd [0:1];
  logic [1:0]         pv;
  logic               act;
  logic [7:0]         base;
  logic [1:0]         s0;
  logic [1:0]         k;
  integer             fails;
  integer             checks;
  integer             cyc;
  integer             seed;

  pbs_sram dut (
    .clk_in                      (clk_in),
    .rst_n_in                    (rst_n_in),
    .addr_in                     (pin[20:13]),
    .chip_select_primary_n_in    (pin[0]),
    .chip_select_second_in       (pin[1]),
    .chip_select_third_n_in      (pin[2]),
    .processor_addr_strobe_n_in  (pin[3]),
    .controller_addr_strobe_n_in (pin[4]),
    .burst_advance_n_in          (pin[5]),
    .burst_order_in              (strap),
    .global_write_n_in           (pin[6]),
    .lane_write_enable_n_in      (pin[7]),
    .lane_select_n_in            (pin[11:8]),
    .out_enable_n_in             (pin[12]),
    .dq_in                       (bus),
    .dq_out                      (dq_out),
    .dq_oe_out                   (dq_oe_out)
  );

  pbs_host_model host (
    .clk_in      (clk_in),
    .oe_n_in     (pin[12]),
    .wr_drive_in (1'b1),
    .wdata_in    (wdata),
    .mem_q_in    (dq_out),
    .mem_oe_in   (dq_oe_out),
    .bus_out     (bus)
  );

  always #5 clk_in = ~clk_in;

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [`PBS_DW-1:0] got, input logic [`PBS_DW-1:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [20:0] mk(input logic [7:0] a, input logic [1:0] stb_n,
                                     input logic adv_n, input logic [1:0] wr_n,
                                     input logic [3:0] ls_n);
    return {a, 1'b0, ls_n, wr_n, adv_n, stb_n, 3'b010};
  endfunction

  function automatic logic [20:0] rnd();
    logic [31:0] r;
    logic [20:0] p;
    r = $random(seed);
    p = r[20:0];
    p[2:0] = (r[31:29] == 3'h0) ? r[2:0] : 3'b010;
    p[4:3] = (r[28:27] == 2'h0) ? r[4:3] : 2'b11;
    p[7:6] = (r[26:25] == 2'h0) ? r[7:6] : 2'b11;
    p[12] = (r[24:23] == 2'h0);
    return p;
  endfunction

  // expected array address of a burst beat, from the order strap
  function automatic logic [7:0] exp_addr(input logic [7:0] b, input logic [1:0] s,
                                          input logic [1:0] n, input logic ord);
    return {b[7:2], ord ? (s ^ n) : (s + n)};
  endfunction

  // expected lane write enables from the write pins; global write wins
  function automatic logic [3:0] exp_lanes(input logic [20:0] p);
    return !p[6] ? 4'hF : (p[7] ? 4'h0 : ~p[11:8]);
  endfunction

  // drive one cycle and advance the reference model
  task automatic step(input logic [20:0] p);
    logic       ps;
    logic       wr;
    logic [7:0] a;
    logic [3:0] we;
    @(negedge clk_in);
    if (pv[1])
      chk(dq_out, pd[1]);
    if (pin[12] || !pv[1])
      chk({35'h0, dq_oe_out}, 36'h0);
    else if (pin[7:6] == 2'b11)
      chk({35'h0, dq_oe_out}, 36'h1);
    pv[1] = pv[0];
    pd[1] = pd[0];
    pv[0] = 1'b0;
    if (p[7:6] != 2'b11)
      p[12] = 1'b1;
    pin = p;
    wdata = `PBS_DW'({$random(seed), $random(seed)});
    ps = !p[3] && !p[0];
    wr = !p[6] || !p[7];
    we = exp_lanes(p);
    if (ps || !p[4])
    begin
      if (!p[0] && p[1] && !p[2])
      begin
        act = 1'b1;
        base = p[20:13];
        s0 = p[14:13];
        k = 2'h0;
        wr = wr && !ps;
      end
      else
      begin
        act = 1'b0;
        pv[1] = 1'b0;
      end
    end
    else if (act && !p[5])
      k = k + 2'h1;
    a = exp_addr(base, s0, k, strap);
    if (act && wr)
    begin
      pv[1] = 1'b0;
      for (int i = 0; i < 4; i++)
        if (we[i])
          mem[a][9*i +: 9] = wdata[9*i +: 9];
    end
    else if (act)
    begin
      pv[0] = 1'b1;
      pd[0] = mem[a];
    end
  endtask

  initial
  begin
    seed = 32'h668e;
    fails = 0;
    checks = 0;
    cyc = 0;
    clk_in = 1'b0;
    strap = 1'b1;
    wdata = '0;
    for (int ph = 0; ph < 2; ph++)
    begin
      strap = (ph == 0);
      rst_n_in = 1'b0;
      pin = mk(8'h00, 2'b11, 1'b1, 2'b11, 4'hF);
      pv = 2'b00;
      act = 1'b0;
      repeat (16) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      if (ph == 0)
        for (int i = 0; i < 256; i++)
          step(mk(i[7:0], 2'b01, 1'b1, 2'b10, 4'hF));
      step(mk(8'h45, 2'b00, 1'b0, 2'b00, 4'h0));
      step(mk(8'h00, 2'b11, 1'b1, 2'b10, 4'hF));
      step(mk(8'h00, 2'b11, 1'b1, 2'b11, 4'hF));
      step(mk(8'h46, 2'b01, 1'b1, 2'b01, 4'hA));
      for (int i = 0; i < 5; i++)
        step(mk(8'h47, (i == 0) ? 2'b01 : 2'b11, (i == 0), 2'b11, 4'hF));
      step(mk(8'h10, 2'b10, 1'b1, 2'b11, 4'hF) | 21'h1);
      step(mk(8'h10, 2'b01, 1'b1, 2'b11, 4'hF) | 21'h1);
      repeat (1500) step(rnd());
      repeat (3) step(mk(8'h00, 2'b11, 1'b1, 2'b11, 4'hF));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
